//--- src/pcl_pkg.sv
// package: shared constants and types for the passive configuration load port
package pcl_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;            // system clock period
	localparam int CFG_LOW_MIN_NS = 500;         // least request low pulse
	localparam int CFG_LOW_CYC = (CFG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CD_LOW_MAX_NS = 500;          // request low to load_complete low
	localparam int CD_LOW_CYC = CD_LOW_MAX_NS / CLK_PERIOD_NS;
	localparam int ST_LOW_MIN_US = 45;           // health pulse least width
	localparam int ST_LOW_MIN_CYC = (ST_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ST_HIGH_MAX_US = 230;         // request high to health high
	localparam int ST_HIGH_MAX_CYC = (ST_HIGH_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int CK_WAIT_US = 230;             // request high to first bit clock edge
	localparam int CK_WAIT_CYC = (CK_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_FAST_US = 3;              // short power-on delay
	localparam int POR_FAST_CYC = (POR_FAST_US * 1000) / CLK_PERIOD_NS;
	localparam int POR_SLOW_US = 100;            // long power-on delay
	localparam int POR_SLOW_CYC = (POR_SLOW_US * 1000) / CLK_PERIOD_NS;
	localparam int HOST_DIV = 4;                 // host bit clock half period in cycles
	localparam int CNT_W = 16;                   // width of timing counters
	localparam logic [31:0] IMAGE_BYTES = 32'h0000_0010; // bytes in one image
	// ----------------------------------------
	// load schemes and flash commands
	// ----------------------------------------
	localparam logic [1:0] SEL_SERIAL = 2'h0;    // serial passive load
	localparam logic [1:0] SEL_PARALLEL = 2'h1;  // parallel passive load
	localparam logic [1:0] SEL_SERIAL_FAST = 2'h2; // serial, short power-on delay
	localparam logic [1:0] SEL_FLASH_LOADER = 2'h3; // flash loader design present
	localparam logic [7:0] FLASH_WRITE_CMD = 8'h02; // page program opcode
	typedef enum logic [2:0] {PCL_POR, PCL_RESET, PCL_WAIT_REL, PCL_LOAD, PCL_USER} pcl_state_e;
	typedef enum logic [1:0] {PCH_IDLE, PCH_PULSE, PCH_WAIT, PCH_SEND} pch_state_e;
endpackage

//--- src/pcl_link_if.sv
// interface: pins between the configuration host and the device
`timescale 1ns/1ps
interface pcl_link_if;
	logic reload_request_n;   // host drives
	logic cfg_bit_clock;      // host drives
	logic [7:0] cfg_data;     // host drives, bit 0 in serial
	logic health_o;           // device open-drain output value
	logic health_oe_n;        // low while device pulls health line
	logic health_in;          // resolved health line
	logic done_o;             // device load_complete value
	logic done_oe_n;          // low while device drives load_complete
	logic done_in;            // resolved load_complete line
	modport device (input reload_request_n, cfg_bit_clock, cfg_data, health_in, done_in,
		output health_o, health_oe_n, done_o, done_oe_n);
	modport host (output reload_request_n, cfg_bit_clock, cfg_data, input health_in, done_in);
endinterface

//--- src/pcl_sync_edge.sv
// module: three-stage pin synchroniser with rise detect
`timescale 1ns/1ps
module pcl_sync_edge (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic level,
	output logic rise
);
	// ----------------------------------------
	// synchroniser
	// ----------------------------------------
	logic [2:0] sh_q;   // stage 0 only feeds stage 1
	logic lvl_q;        // accepted level
	// a change counts once stages 1 and 2 agree
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sh_q <= 3'h7;
			lvl_q <= 1'b1;
		end else begin
			sh_q <= {sh_q[1:0], pin};
			if (sh_q[1] == sh_q[2]) lvl_q <= sh_q[2];
		end
	end
	assign level = lvl_q;
	assign rise = (sh_q[1] == sh_q[2]) && sh_q[2] && !lvl_q;
endmodule

//--- src/pcl_device.sv
// module: device end of the passive configuration load port
`timescale 1ns/1ps
module pcl_device (
	input wire logic clk,
	input wire logic rst_b,
	pcl_link_if.device link,
	input wire logic [1:0] scheme_select,
	input wire logic scan_bit,
	input wire logic scan_bit_valid,
	input wire logic user_rd_ready,
	output logic user_rd_valid,
	output logic [7:0] user_rd_data,
	output logic [7:0] user_io_in,
	output logic user_mode,
	output logic flash_clk,
	output logic flash_cs_n,
	output logic flash_mosi
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic req_lvl;     // synchronised request level
	logic clk_lvl;     // synchronised bit clock level
	logic clk_rise;    // bit clock rising edge
	logic [7:0] d_sync1_q, d_sync2_q, d_sync3_q; // data bus path, three stages like the other pins
	pcl_sync_edge u_req (.clk(clk), .rst_b(rst_b), .pin(link.reload_request_n), .level(req_lvl), .rise());
	pcl_sync_edge u_bck (.clk(clk), .rst_b(rst_b), .pin(link.cfg_bit_clock), .level(clk_lvl), .rise(clk_rise));
	// data pins stand still for the whole high phase of the bit clock, so the last stage
	// still holds the value from just after the rise when that rise is seen
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			d_sync1_q <= 8'h00;
			d_sync2_q <= 8'h00;
			d_sync3_q <= 8'h00;
		end else begin
			d_sync1_q <= link.cfg_data;
			d_sync2_q <= d_sync1_q;
			d_sync3_q <= d_sync2_q;
		end
	end
	// ----------------------------------------
	// scheme capture after reset release
	// ----------------------------------------
	logic [1:0] sel_q;      // scheme caught once
	logic sel_taken_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sel_q <= 2'h0;
			sel_taken_q <= 1'b0;
		end else if (!sel_taken_q) begin
			sel_q <= scheme_select;
			sel_taken_q <= 1'b1;
		end
	end
	wire is_par = (sel_q == pcl_pkg::SEL_PARALLEL);
	wire is_sfl = (sel_q == pcl_pkg::SEL_FLASH_LOADER);
	// short delay on the fast setting, long otherwise
	wire [pcl_pkg::CNT_W-1:0] por_len = (sel_q == pcl_pkg::SEL_SERIAL_FAST) ?
		pcl_pkg::CNT_W'(pcl_pkg::POR_FAST_CYC) : pcl_pkg::CNT_W'(pcl_pkg::POR_SLOW_CYC);
	// ----------------------------------------
	// configuration sequencer
	// ----------------------------------------
	pcl_pkg::pcl_state_e st_q, st_d;
	logic [pcl_pkg::CNT_W-1:0] cnt_q, cnt_d;   // timing counter
	logic [pcl_pkg::CNT_W-1:0] lowc_q;         // request low length
	logic [31:0] bytes_q;                      // bytes received
	logic [2:0] bit_q;                         // serial bit index
	logic [7:0] shf_q;                         // serial assembly
	wire req_ok = (lowc_q >= pcl_pkg::CNT_W'(pcl_pkg::CFG_LOW_CYC));
	wire req_fall = !req_lvl && (st_q == pcl_pkg::PCL_USER || st_q == pcl_pkg::PCL_LOAD) && req_ok;
	wire load_done = (bytes_q >= pcl_pkg::IMAGE_BYTES);
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + pcl_pkg::CNT_W'(1);
		case (st_q)
			pcl_pkg::PCL_POR: begin
				if (cnt_q >= por_len) begin
					st_d = pcl_pkg::PCL_RESET;
					cnt_d = '0;
				end
			end
			pcl_pkg::PCL_RESET: begin
				// health pulse at least the least width, while request stays low
				if (cnt_q >= pcl_pkg::CNT_W'(pcl_pkg::ST_LOW_MIN_CYC) && req_lvl) begin
					st_d = pcl_pkg::PCL_LOAD;
					cnt_d = '0;
				end
			end
			pcl_pkg::PCL_LOAD: begin
				if (req_fall) begin
					st_d = pcl_pkg::PCL_RESET;
					cnt_d = '0;
				end else if (load_done || is_sfl) begin
					st_d = pcl_pkg::PCL_USER;
				end
			end
			pcl_pkg::PCL_USER: begin
				if (req_fall) begin
					st_d = pcl_pkg::PCL_RESET;
					cnt_d = '0;
				end
			end
			default: st_d = pcl_pkg::PCL_POR;
		endcase
	end
	// timing counter and state register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q <= pcl_pkg::PCL_POR;
			cnt_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= (cnt_d == '1) ? cnt_q : cnt_d;
		end
	end
	// measure how long the request has been low; glitches below the minimum are ignored
	always_ff @(posedge clk) begin
		if (!rst_b) lowc_q <= '0;
		else if (req_lvl) lowc_q <= '0;
		else if (!req_ok) lowc_q <= lowc_q + pcl_pkg::CNT_W'(1);
	end
	// ----------------------------------------
	// data capture
	// ----------------------------------------
	wire in_load = (st_q == pcl_pkg::PCL_LOAD);
	wire take = in_load && clk_rise;
	wire [7:0] ser_byte = {d_sync3_q[0], shf_q[7:1]};  // lsb first
	wire byte_ready = take && (is_par || bit_q == 3'h7);
	always_ff @(posedge clk) begin
		if (!rst_b || !in_load) begin
			bit_q <= 3'h0;
			shf_q <= 8'h00;
			bytes_q <= 32'h0;
		end else if (take) begin
			shf_q <= ser_byte;
			bit_q <= is_par ? 3'h0 : bit_q + 3'h1;
			if (byte_ready) bytes_q <= bytes_q + 32'h1;
		end
	end
	// two-entry buffer toward the user side; a byte that arrives while the buffer is
	// full is dropped, but bytes_q still counts it, so loading still completes
	logic [7:0] buf_q [2];
	logic [1:0] cnt_b_q;
	logic wp_q, rp_q;
	wire push = byte_ready && (cnt_b_q != 2'h2);
	wire pop = user_rd_valid && user_rd_ready;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_b_q <= 2'h0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
		end else begin
			if (push) begin
				buf_q[wp_q] <= is_par ? d_sync3_q : ser_byte;
				wp_q <= !wp_q;
			end
			if (pop) rp_q <= !rp_q;
			cnt_b_q <= cnt_b_q + {1'b0, push} - {1'b0, pop};
		end
	end
	assign user_rd_valid = (cnt_b_q != 2'h0);
	assign user_rd_data = buf_q[rp_q];
	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	wire hold_health = (st_q == pcl_pkg::PCL_POR) || (st_q == pcl_pkg::PCL_RESET);
	// drop load_complete as soon as the request is seen low, without waiting for the
	// minimum width; waiting would land the fall well past the allowed time
	wire hold_done = (st_q != pcl_pkg::PCL_USER) || !req_lvl;
	assign link.health_o = 1'b0;
	assign link.health_oe_n = !hold_health;
	assign link.done_o = 1'b0;
	assign link.done_oe_n = !hold_done;
	assign user_mode = (st_q == pcl_pkg::PCL_USER);
	// after loading the parallel bus is plain user input
	always_ff @(posedge clk) begin
		if (!rst_b) user_io_in <= 8'h00;
		else if (user_mode && is_par) user_io_in <= d_sync3_q;
	end
	// ----------------------------------------
	// scan to serial flash forwarding
	// ----------------------------------------
	logic fwd_clk_q, fwd_cs_q, fwd_do_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fwd_clk_q <= 1'b0;
			fwd_cs_q <= 1'b1;
			fwd_do_q <= 1'b0;
		end else if (user_mode && is_sfl) begin
			fwd_cs_q <= !scan_bit_valid;
			fwd_do_q <= scan_bit;
			fwd_clk_q <= scan_bit_valid && !fwd_clk_q;
		end else begin
			fwd_cs_q <= 1'b1;
			fwd_clk_q <= 1'b0;
		end
	end
	assign flash_clk = fwd_clk_q;
	assign flash_cs_n = fwd_cs_q;
	assign flash_mosi = fwd_do_q;
	wire unused_ok = clk_lvl ^ link.health_in ^ link.done_in;
endmodule

//--- src/pcl_host.sv
// module: host end that drives a reload and clocks an image in
`timescale 1ns/1ps
module pcl_host (
	input wire logic clk,
	input wire logic rst_b,
	pcl_link_if.host link,
	input wire logic start,
	input wire logic parallel_mode,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	output logic busy,
	output logic done
);
	// ----------------------------------------
	// status line sync
	// ----------------------------------------
	logic st_lvl, cd_lvl;
	pcl_sync_edge u_st (.clk(clk), .rst_b(rst_b), .pin(link.health_in), .level(st_lvl), .rise());
	pcl_sync_edge u_cd (.clk(clk), .rst_b(rst_b), .pin(link.done_in), .level(cd_lvl), .rise());
	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	pcl_pkg::pch_state_e st_q;
	logic [pcl_pkg::CNT_W-1:0] cnt_q;
	logic ck_q, req_q;
	logic [7:0] sh_q, dat_q;
	logic [2:0] bit_q;
	logic have_q;
	wire half = (cnt_q == pcl_pkg::CNT_W'(pcl_pkg::HOST_DIV - 1));
	assign wr_ready = (st_q == pcl_pkg::PCH_SEND) && !have_q;
	assign busy = (st_q != pcl_pkg::PCH_IDLE);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q <= pcl_pkg::PCH_IDLE;
			cnt_q <= '0;
			ck_q <= 1'b0;
			req_q <= 1'b1;
			sh_q <= 8'h00;
			dat_q <= 8'h00;
			bit_q <= 3'h0;
			have_q <= 1'b0;
			done <= 1'b0;
		end else begin
			cnt_q <= cnt_q + pcl_pkg::CNT_W'(1);
			case (st_q)
				pcl_pkg::PCH_IDLE: begin
					if (start) begin
						st_q <= pcl_pkg::PCH_PULSE;
						req_q <= 1'b0;
						cnt_q <= '0;
						done <= 1'b0;
					end
				end
				pcl_pkg::PCH_PULSE: begin
					if (cnt_q >= pcl_pkg::CNT_W'(pcl_pkg::CFG_LOW_CYC)) begin
						req_q <= 1'b1;
						st_q <= pcl_pkg::PCH_WAIT;
						cnt_q <= '0;
					end
				end
				pcl_pkg::PCH_WAIT: begin
					if (cnt_q >= pcl_pkg::CNT_W'(pcl_pkg::CK_WAIT_CYC) && st_lvl) begin
						st_q <= pcl_pkg::PCH_SEND;
						cnt_q <= '0;
					end
				end
				pcl_pkg::PCH_SEND: begin
					if (wr_ready && wr_valid) begin
						sh_q <= wr_data;
						have_q <= 1'b1;
						bit_q <= 3'h0;
					end
					if (half) begin
						cnt_q <= '0;
						if (ck_q) begin
							// falling edge: data changes away from the rise
							ck_q <= 1'b0;
							if (have_q) begin
								if (parallel_mode || bit_q == 3'h7) have_q <= 1'b0;
								else begin
									bit_q <= bit_q + 3'h1;
									sh_q <= {1'b0, sh_q[7:1]};
								end
							end
						end else if (have_q) begin
							dat_q <= parallel_mode ? sh_q : {7'h00, sh_q[0]};
							ck_q <= 1'b1;
						end
					end
					if (cd_lvl && !have_q && !ck_q) begin
						st_q <= pcl_pkg::PCH_IDLE;
						done <= 1'b1;
					end
				end
				default: st_q <= pcl_pkg::PCH_IDLE;
			endcase
		end
	end
	// data is set up while the bit clock is low before each rise: on the fall for serial bits 1 to 7, when the byte is taken otherwise
	assign link.cfg_data = (st_q == pcl_pkg::PCH_SEND && !ck_q && have_q) ?
		(parallel_mode ? sh_q : {7'h00, sh_q[0]}) : dat_q;
	assign link.reload_request_n = req_q;
	assign link.cfg_bit_clock = ck_q;
endmodule

//--- sim/pcl_link_properties.sv
// checker: timing properties watched on the configuration link pins
`timescale 1ns/1ps
module pcl_link_properties (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reload_request_n,
	input wire logic cfg_bit_clock,
	input wire logic [7:0] cfg_data,
	input wire logic health_in,
	input wire logic done_in
);
	logic [15:0] lo_q; // cycles with request low
	logic [15:0] hl_q; // cycles with health low
	logic [15:0] up_q; // cycles since request went high
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	// saturate, so a long idle never wraps into a false pass
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lo_q <= 16'h0;
			hl_q <= 16'h0;
			up_q <= 16'h0;
		end else begin
			lo_q <= reload_request_n ? 16'h0 : lo_q + {15'h0, lo_q != 16'hffff};
			hl_q <= health_in ? 16'h0 : hl_q + {15'h0, hl_q != 16'hffff};
			up_q <= !reload_request_n ? 16'h0 : up_q + {15'h0, up_q != 16'hffff};
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_done_low_fast: assert property ($fell(reload_request_n) ##1 !reload_request_n[*8] |-> ##[0:54] !done_in)
		else $error("load_complete not low soon after request");
	a_req_width: assert property ($rose(reload_request_n) |-> lo_q >= 16'd63)
		else $error("request low pulse too short");
	a_health_min: assert property ($rose(health_in) |-> hl_q >= 16'd5625)
		else $error("health pulse too short");
	a_health_max: assert property ($rose(health_in) |-> hl_q <= 16'd28750)
		else $error("health pulse too long");
	a_health_release: assert property (!health_in && reload_request_n |-> up_q <= 16'd28750)
		else $error("health not released in time");
	a_done_in_reset: assert property (!health_in |-> !done_in)
		else $error("load_complete high during reset");
	a_clock_wait: assert property ($rose(cfg_bit_clock) |-> up_q >= 16'd28750)
		else $error("bit clock started too early");
	a_data_steady: assert property ($rose(cfg_bit_clock) |-> $stable(cfg_data) ##1 $stable(cfg_data))
		else $error("data moved at bit clock rise");
	a_user_hold: assert property (done_in && reload_request_n |=> done_in)
		else $error("load_complete dropped in user mode");
	a_clock_high: assert property ($rose(cfg_bit_clock) |-> cfg_bit_clock[*4] ##1 !cfg_bit_clock)
		else $error("bit clock high phase wrong");
	c_done: cover property ($rose(done_in));
	c_health: cover property ($rose(health_in));
	c_request: cover property ($fell(reload_request_n));
endmodule

//--- sim/test_passive_config_load_port.sv
// testbench: host and device joined, serial, parallel and flash loader runs
`timescale 1ns/1ps
module test_passive_config_load_port;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] scheme_select = 2'h2;
	logic scan_bit = 1'b0;
	logic scan_bit_valid = 1'b0;
	logic user_rd_ready = 1'b1;
	logic start = 1'b0;
	logic parallel_mode = 1'b0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic slave_low = 1'b0; // other devices holding load_complete low
	logic user_rd_valid, user_mode, flash_clk, flash_cs_n, flash_mosi, wr_ready, busy, done, ck_q, fq;
	logic [7:0] user_rd_data, user_io_in, sh;
	logic [7:0] got[$];
	logic [7:0] wire_q[$];
	logic fbits[$];
	int nb = 0;
	int cyc = 0;
	int n_errors = 0;
	int cmp_count = 0;
	pcl_link_if link();
	// pull-ups on both open-drain lines
	assign link.health_in = link.health_oe_n ? 1'b1 : link.health_o;
	assign link.done_in = (link.done_oe_n ? 1'b1 : link.done_o) & ~slave_low;
	pcl_device i_pcl_device(.clk(clk), .rst_b(rst_b), .link(link), .scheme_select(scheme_select),
		.scan_bit(scan_bit), .scan_bit_valid(scan_bit_valid), .user_rd_ready(user_rd_ready),
		.user_rd_valid(user_rd_valid), .user_rd_data(user_rd_data), .user_io_in(user_io_in), .user_mode(user_mode),
		.flash_clk(flash_clk), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi));
	pcl_host i_pcl_host(.clk(clk), .rst_b(rst_b), .link(link), .start(start), .parallel_mode(parallel_mode),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .busy(busy), .done(done));
	pcl_link_properties i_pcl_link_properties(.clk(clk), .rst_b(rst_b), .reload_request_n(link.reload_request_n),
		.cfg_bit_clock(link.cfg_bit_clock), .cfg_data(link.cfg_data), .health_in(link.health_in),
		.done_in(link.done_in));
	always #4 clk = ~clk;
	// ----------------------------------------
	// monitors and timeout
	// ----------------------------------------
	// reader stalls 8 of every 64 cycles: short enough that the two-entry buffer never overflows
	always @(posedge clk) begin
		cyc <= cyc + 1;
		user_rd_ready <= #1 (cyc[5:3] != 3'h7);
		ck_q <= link.cfg_bit_clock;
		fq <= flash_clk;
		if (user_rd_valid && user_rd_ready)
			got.push_back(user_rd_data);
		if (flash_clk && !fq && !flash_cs_n)
			fbits.push_back(flash_mosi);
		if (rst_b && link.cfg_bit_clock && !ck_q) begin
			sh = {link.cfg_data[0], sh[7:1]};
			nb = nb + 1;
			if (parallel_mode)
				wire_q.push_back(link.cfg_data);
			else if (nb % 8 == 0)
				wire_q.push_back(sh);
		end
		if (cyc == 120000) begin
			n_errors++;
			conclude();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	function automatic logic [7:0] img(input int i);
		return {i[3:0], ~i[3:0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// reset under a scheme and time the health release
	task automatic power_up(input logic [1:0] sel, input int exp);
		int n;
		n = 0;
		rst_b = 1'b0;
		scheme_select = sel;
		tick(2);
		rst_b = 1'b1;
		got.delete();
		wire_q.delete();
		nb = 0;
		while (link.health_in !== 1'b1 && n < 30000) begin
			check(32'(link.done_in), 32'h0);
			tick(1);
			n++;
		end
		check(32'(n >= exp && n <= exp + 16), 32'h1);
	endtask
	// one full image load, then compare wire bytes and delivered bytes
	task automatic load(input logic par);
		int k;
		k = 0;
		parallel_mode = par;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		for (int i = 0; i < 16; i++) begin
			wr_valid = 1'b1;
			wr_data = img(i);
			// wait until ready stands settled, then let the next edge take the byte
			while (wr_ready !== 1'b1 && k < 40000) begin
				tick(1);
				k++;
			end
			tick(1);
		end
		wr_valid = 1'b0;
		while (link.done_in !== 1'b1 && k < 40000) begin
			tick(1);
			k++;
		end
		tick(64);
		check(32'(wire_q.size()), 32'd16);
		check(32'(got.size()), 32'd16);
		for (int i = 0; i < 16; i++) begin
			check(32'(wire_q[i]), 32'(img(i)));
			check(32'(got[i]), 32'(img(i)));
		end
		check(32'({done, user_mode, link.health_in, busy}), 32'he);
		check(32'(link.cfg_bit_clock === 1'b0 || link.cfg_bit_clock === 1'b1), 32'h1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic serial_scenario();
		power_up(pcl_pkg::SEL_SERIAL_FAST, pcl_pkg::POR_FAST_CYC + pcl_pkg::ST_LOW_MIN_CYC);
		load(1'b0);
	endtask
	// parallel load, then a reload request out of user mode
	task automatic parallel_scenario();
		int n;
		n = 0;
		power_up(pcl_pkg::SEL_PARALLEL, pcl_pkg::POR_SLOW_CYC + pcl_pkg::ST_LOW_MIN_CYC);
		load(1'b1);
		check(32'(user_io_in), 32'(link.cfg_data));
		start = 1'b1;
		tick(1);
		start = 1'b0;
		while (link.done_in !== 1'b0 && n < 200) begin
			tick(1);
			n++;
		end
		check(32'(n <= pcl_pkg::CD_LOW_CYC + 1), 32'h1);
		tick(100);
		check(32'(link.health_in), 32'h0);
	endtask
	// flash loader: user mode with load_complete held low, scan bits reach flash
	task automatic flash_scenario();
		logic [7:0] pat;
		pat = 8'ha6;
		slave_low = 1'b1;
		power_up(pcl_pkg::SEL_FLASH_LOADER, pcl_pkg::POR_SLOW_CYC + pcl_pkg::ST_LOW_MIN_CYC);
		tick(8);
		check(32'(user_mode), 32'h1);
		fbits.delete();
		for (int i = 7; i >= 0; i--) begin
			scan_bit = pat[i];
			scan_bit_valid = 1'b1;
			tick(1);
			scan_bit_valid = 1'b0;
			tick(15);
		end
		tick(64);
		check(32'(fbits.size() >= 8), 32'h1);
		for (int i = 0; i < 8 && i < fbits.size(); i++)
			check(32'(fbits[i]), 32'(pat[7 - i]));
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		serial_scenario();
		parallel_scenario();
		flash_scenario();
		conclude();
	end
endmodule
